// ==== bench/avfr_aux_voltage_fault_response_tb_top.sv ====
// Purpose: Directed test of fault modes, retry timing and registers
// Assumes: Tick shortened to 10 cycles per millisecond
// Notes:   Voltages in Q16.16; limits at reset values until the last check
`timescale 1ns/1ps
module avfr_aux_voltage_fault_response_tb_top;
    import avfr_pkg::*;
    localparam int  TICK = 10;
    localparam int  STEP = RETRY_STEP_MS * TICK;
    localparam logic [31:0] V_NOM = 32'h10000;
    localparam logic [31:0] V_HI  = 32'h30000;
    localparam logic [31:0] V_MID = 32'h25800; // Above 95 percent, below limit
    localparam logic [31:0] V_LIM = 32'h24000; // Between lowered and reset OV limits
    logic        sys_clk     = 1'b0;
    logic        rst         = 1'b1;
    logic [31:0] voltage     = V_NOM;
    logic        commandedOn = 1'b1;
    logic        biasGood    = 1'b1;
    logic        otherFault  = 1'b0;
    int          nErrors = 0;
    int          samplesChecked = 0;
    int          cycles = 0;
    logic [15:0] readData;
    logic [15:0] rd;
    logic        outputEnable;
    logic        alertLineN;
    avfr_flags_t faultFlags;
    avfr_cmd_t   cmd;
    logic [7:0]  codes [5] = '{CMD_OV_RESPONSE, CMD_UV_RESPONSE, CMD_OV_LIMIT, CMD_UV_LIMIT, 8'h7a};
    logic [15:0] resets [5] = '{16'h00bf, 16'h00bf, 16'hc266, 16'h9b33, 16'h0};
    always #5 sys_clk = ~sys_clk;
    avfr_aux_voltage_fault_response #(.CYCLES_PER_TICK(TICK)) DUT (.sys_clk(sys_clk), .rst(rst),
        .cmd(cmd), .readData(readData), .auxMonitorVoltage(voltage), .commandedOn(commandedOn),
        .biasGood(biasGood), .otherFaultShutdown(otherFault), .outputEnable(outputEnable),
        .alertLineN(alertLineN), .faultFlags(faultFlags));
    avfr_host_model host (.sys_clk(sys_clk), .readData(readData), .cmd(cmd));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle
    // Alert follows the flags; then output enable, over and under flags
    task automatic expOut(input logic [2:0] e);
        check({12'h0, alertLineN, outputEnable, faultFlags}, {12'h0, ~(e[1] | e[0]), e});
    endtask : expOut
    task automatic giveVerdict();
        if (nErrors == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : giveVerdict
    // Ceiling well above the roughly 4000 cycles of the sequence
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nErrors++;
            giveVerdict();
        end
    end
    initial begin
        idle(20);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            host.fetch(codes[i], rd);
            check(rd, resets[i]);
        end
        host.send(1'b1, CMD_UV_RESPONSE, 16'h5a00);
        host.fetch(CMD_UV_RESPONSE, rd);
        check(rd, 16'h0);
        for (int m = 0; m < 2; m++) begin
            host.send(1'b1, CMD_OV_RESPONSE, {8'h0, m[1:0], 6'h3f});
            voltage = V_HI;
            idle(3);
            expOut(3'b100);
            voltage = V_NOM;
        end
        host.send(1'b1, CMD_OV_RESPONSE, 16'h0080);
        voltage = V_HI;
        idle(2);
        expOut(3'b010);
        voltage = V_NOM;
        idle(2 * STEP);
        expOut(3'b010);
        host.clear();
        idle(2);
        expOut(3'b100);
        host.send(1'b1, CMD_OV_RESPONSE, 16'h00c0);
        voltage = V_HI;
        idle(2);
        expOut(3'b010);
        voltage = V_NOM;
        idle(2);
        expOut(3'b110);
        host.clear();
        host.send(1'b1, CMD_OV_RESPONSE, 16'h00b9);
        voltage = V_HI;
        idle(2);
        voltage = V_MID;
        idle(2 * STEP + 10);
        expOut(3'b010);
        voltage = V_NOM;
        idle(2 * STEP + 5);
        expOut(3'b110);
        host.clear();
        voltage = V_HI;
        idle(1);
        voltage = V_NOM;
        idle(2 * STEP - 10);
        expOut(3'b010);
        idle(20);
        expOut(3'b110);
        host.clear();
        host.send(1'b1, CMD_UV_RESPONSE, 16'h00b8);
        voltage = 32'h0;
        idle(3 * STEP);
        expOut(3'b001);
        voltage = V_NOM;
        idle(STEP + 5);
        expOut(3'b101);
        host.clear();
        for (int k = 0; k < 3; k++) begin
            {commandedOn, biasGood, otherFault} = 3'b110 ^ (3'b100 >> k);
            idle(3);
            expOut(3'b000);
            {commandedOn, biasGood, otherFault} = 3'b110;
            idle(3);
            host.clear();
            idle(3);
            expOut(3'b100);
        end
        // Lowered OV limit must trip a level the reset limit would pass
        host.send(1'b1, CMD_OV_LIMIT, 16'hc200);
        host.send(1'b1, CMD_UV_LIMIT, 16'h9b00);
        host.fetch(CMD_OV_LIMIT, rd);
        check(rd, 16'hc200);
        host.fetch(CMD_UV_LIMIT, rd);
        check(rd, 16'h9b00);
        voltage = V_LIM;
        idle(2);
        expOut(3'b010);
        giveVerdict();
    end
endmodule : avfr_aux_voltage_fault_response_tb_top

// ==== bench/avfr_host_model.sv ====
// Purpose: Host side issuing configuration and clear commands
// Assumes: Commands held from a falling edge through the taking edge
// Notes:   Released fields show inverted junk, not the last value
`timescale 1ns/1ps
module avfr_host_model (
    // Command side
    input  wire logic          sys_clk,
    input  wire logic [15:0]   readData,
    output avfr_pkg::avfr_cmd_t cmd
);
    import avfr_pkg::*;
    initial cmd = '0;
    task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
        @(negedge sys_clk);
        cmd = '{1'b1, wr, code, data};
        @(posedge sys_clk);
        @(negedge sys_clk);
        cmd = '{1'b0, ~wr, ~code, ~data};
    endtask : send
    task automatic fetch(input logic [7:0] code, output logic [15:0] d);
        send(1'b0, code, 16'h0);
        d = readData;
    endtask : fetch
    task automatic clear();
        send(1'b1, CMD_CLEAR_FAULTS, 16'h0);
    endtask : clear
endmodule : avfr_host_model

// ==== bench/avfr_properties.sv ====
// Purpose: Port checker for the aux fault response block
// Assumes: Trip levels use reset limits; the bench changes them only last
// Notes:   Gap counter runs while the output is off
`timescale 1ns/1ps
module avfr_properties #(
    parameter int CYCLES_PER_TICK = 10,
    parameter int MONITOR_WIDTH   = 32
) (
    // Watched ports
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire avfr_pkg::avfr_cmd_t      cmd,
    input wire logic [15:0]              readData,
    input wire logic [MONITOR_WIDTH-1:0] auxMonitorVoltage,
    input wire logic                     commandedOn,
    input wire logic                     biasGood,
    input wire logic                     otherFaultShutdown,
    input wire logic                     outputEnable,
    input wire logic                     alertLineN,
    input wire avfr_pkg::avfr_flags_t    faultFlags
);
    import avfr_pkg::*;
    localparam int STEP = RETRY_STEP_MS * CYCLES_PER_TICK;
    logic [7:0]  ovResp_r;
    logic [7:0]  uvResp_r;
    logic [15:0] gap_r;
    wire wr     = cmd.valid && cmd.write;
    wire clrCmd = wr && cmd.code == CMD_CLEAR_FAULTS;
    wire ovTrip = ovResp_r[7] && auxMonitorVoltage > 32'h26600;
    wire uvTrip = uvResp_r[7] && auxMonitorVoltage < 32'h1998;
    wire known  = cmd.code inside {CMD_OV_LIMIT, CMD_UV_LIMIT, CMD_OV_RESPONSE,
                                   CMD_UV_RESPONSE, CMD_CLEAR_FAULTS};
    wire ovHeld  = faultFlags.overVoltage && !clrCmd;
    wire latchOn = ovResp_r[7:3] == 5'b10000 && faultFlags.overVoltage
                   && !outputEnable && !clrCmd;
    wire stopReq = !biasGood || !commandedOn || otherFaultShutdown;
    wire ovCont  = ovResp_r[7:3] == 5'b10111 && faultFlags.overVoltage;
    wire rdOther = cmd.valid && !cmd.write && !known;
    wire [15:0] minGap = 16'(STEP * (int'(ovResp_r[2:0]) + 1) - 2);
    always_ff @(posedge sys_clk) begin
        ovResp_r <= rst ? RESP_RESET : (wr && cmd.code == CMD_OV_RESPONSE) ?
                    cmd.data[7:0] : ovResp_r;
        uvResp_r <= rst ? RESP_RESET : (wr && cmd.code == CMD_UV_RESPONSE) ?
                    cmd.data[7:0] : uvResp_r;
        gap_r    <= (rst || outputEnable) ? 16'h0 : gap_r + 16'h1;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_clear;
        clrCmd && !ovTrip && !uvTrip;
    endsequence
    a_alert_flags: assert property (alertLineN == !(|faultFlags))
        else $error("alert level disagrees with flags");
    a_ov_flag_set: assert property (ovTrip |=> faultFlags.overVoltage)
        else $error("trip did not set flag");
    a_flag_sticky: assert property (ovHeld |=> faultFlags.overVoltage)
        else $error("flag dropped without clear");
    a_clear_faults: assert property (s_clear |=> faultFlags == '0)
        else $error("clear left a flag");
    a_trip_off: assert property (ovTrip || uvTrip |-> !outputEnable)
        else $error("output on during trip");
    a_latch_holds: assert property (latchOn |=> !outputEnable)
        else $error("latched output restarted");
    a_off_no_bias: assert property (stopReq |=> !outputEnable)
        else $error("output on while stopped");
    a_retry_gap: assert property ($rose(outputEnable) && ovCont |-> gap_r >= minGap)
        else $error("retry came too early");
    a_unknown_read: assert property (rdOther |=> readData == 16'h0)
        else $error("unknown code read nonzero");
endmodule : avfr_properties
bind avfr_aux_voltage_fault_response avfr_properties #(
    .CYCLES_PER_TICK(CYCLES_PER_TICK), .MONITOR_WIDTH(MONITOR_WIDTH)) chk (.sys_clk, .rst,
    .cmd, .readData, .auxMonitorVoltage, .commandedOn, .biasGood, .otherFaultShutdown,
    .outputEnable, .alertLineN, .faultFlags);

// ==== verilog/avfr_aux_voltage_fault_response.sv ====
// Purpose: Aux monitor over/under-voltage fault response and retry sequencer
// Assumes: All inputs synchronous to sys_clk; one command per valid cycle
// Notes:   Write protection and readback of the monitor are handled elsewhere
//
// Summary of operation
// - Response 00 ignores faults; 01 treated alike
// - Response 10 shuts off, then retry policy
// - Response 11 holds off while fault persists
// - Fault under response 10 or 11 drives alert low, sets status flag
// - Flags clear only on clear-faults command
// - Retry 000 latches off until faults cleared
// - Retry 111 restarts until off, bias, fault
// - Over-voltage retry waits for 95 percent limit
// - Interval is (delay plus one) times 35 ms
// - Interval measured from trip to next attempt
// - Separate under-voltage response register, same layout
// - Programmable over-voltage limit, default C266h, compared
`timescale 1ns/1ps
module avfr_aux_voltage_fault_response #(
    parameter int CYCLES_PER_TICK = avfr_pkg::CYCLES_PER_MS,
    parameter int MONITOR_WIDTH   = 32
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // Command port
    input  wire avfr_pkg::avfr_cmd_t        cmd,
    output logic [15:0]                     readData,
    // Monitor and power control
    input  wire logic [MONITOR_WIDTH-1:0]   auxMonitorVoltage,
    input  wire logic                       commandedOn,
    input  wire logic                       biasGood,
    input  wire logic                       otherFaultShutdown,
    // Results
    output logic                            outputEnable,
    output logic                            alertLineN,
    output avfr_pkg::avfr_flags_t           faultFlags
);
    import avfr_pkg::*;

    // Monitor is widened to 48 bits for the limit compare
    if (CYCLES_PER_TICK < 1 || MONITOR_WIDTH < 1 || MONITOR_WIDTH > 40) begin : gParamCheck
        $error("avfr: unsupported parameter values");
    end

    typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_HOLD, ST_LATCH, ST_WAIT} avfr_state_t;

    // Linear-11 to unsigned Q.16 volts; negative values read as zero
    function automatic logic [47:0] lin11ToFix(input logic [15:0] lin);
        logic signed [4:0]  expo;
        logic        [10:0] mant;
        logic        [47:0] wide;
        logic        [5:0]  sh;
        expo = lin[15:LIN_EXP_LO];
        mant = lin[LIN_MANT_HI:0];
        sh   = 6'(FIX_FRAC_BITS + int'(expo));
        wide = mant[LIN_MANT_HI] ? 48'h0 : (48'(mant) << sh);
        return wide;
    endfunction : lin11ToFix

    function automatic logic respActive(input logic [7:0] resp);
        logic [1:0] mode;
        mode = resp[RESP_MODE_HI:RESP_MODE_LO];
        return (mode == MODE_RETRY) || (mode == MODE_WHILE);
    endfunction : respActive

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]   ovResp_r;
    logic [7:0]   uvResp_r;
    logic [15:0]  ovLimit_r;
    logic [15:0]  uvLimit_r;
    logic [7:0]   actResp_r;
    logic         srcOv_r;
    avfr_state_t  state_r;
    avfr_state_t  state_nxt;
    avfr_flags_t  flags_r;
    logic [31:0]  tickCnt_r;
    logic [8:0]   msCnt_r;
    logic         timerClr;

    wire         wrCmd     = cmd.valid && cmd.write;
    wire         clearCmd  = wrCmd && (cmd.code == CMD_CLEAR_FAULTS);
    wire [47:0]  volt      = 48'(auxMonitorVoltage);
    wire [47:0]  ovLimFix  = lin11ToFix(ovLimit_r);
    wire [47:0]  uvLimFix  = lin11ToFix(uvLimit_r);
    wire         ovPresent = volt > ovLimFix;
    wire         uvPresent = volt < uvLimFix;
    wire [55:0]  voltPct   = 56'(volt) * 56'(FULL_PCT);
    wire [55:0]  limPct    = 56'(ovLimFix) * 56'(RESTART_PCT);
    wire         ovBelowRestart = voltPct < limPct;
    wire         ovTrip    = ovPresent && respActive(ovResp_r);
    wire         uvTrip    = uvPresent && respActive(uvResp_r);
    wire [7:0]   tripResp  = ovTrip ? ovResp_r : uvResp_r;
    wire [1:0]   tripMode  = tripResp[RESP_MODE_HI:RESP_MODE_LO];
    wire [2:0]   tripRetry = tripResp[RESP_RETRY_HI:RESP_RETRY_LO];
    wire [2:0]   actDelay  = actResp_r[RESP_DELAY_HI:RESP_DELAY_LO];
    wire [8:0]   retryMs   = 9'((10'(actDelay) + 10'd1) * 10'(RETRY_STEP_MS));
    wire         timerDone = msCnt_r >= retryMs;
    wire         srcPresent = srcOv_r ? ovPresent : uvPresent;
    wire         tick      = tickCnt_r == 32'(CYCLES_PER_TICK - 1);
    wire         powerOk   = commandedOn && biasGood;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovResp_r  <= RESP_RESET;
            uvResp_r  <= RESP_RESET;
            ovLimit_r <= OV_LIMIT_RESET;
            uvLimit_r <= UV_LIMIT_RESET;
        end else if (wrCmd) begin
            if (cmd.code == CMD_OV_RESPONSE) ovResp_r  <= cmd.data[7:0];
            if (cmd.code == CMD_UV_RESPONSE) uvResp_r  <= cmd.data[7:0];
            if (cmd.code == CMD_OV_LIMIT)    ovLimit_r <= cmd.data;
            if (cmd.code == CMD_UV_LIMIT)    uvLimit_r <= cmd.data;
        end
    end

    wire [15:0] readMux =
        (cmd.code == CMD_OV_RESPONSE) ? {8'h00, ovResp_r} :
        (cmd.code == CMD_UV_RESPONSE) ? {8'h00, uvResp_r} :
        (cmd.code == CMD_OV_LIMIT)    ? ovLimit_r :
        (cmd.code == CMD_UV_LIMIT)    ? uvLimit_r : 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (rst)
            readData <= 16'h0000;
        else if (cmd.valid && !cmd.write)
            readData <= readMux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags; a new trip beats a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (rst)
            flags_r <= '0;
        else begin
            flags_r.overVoltage  <= ovTrip || (flags_r.overVoltage && !clearCmd);
            flags_r.underVoltage <= uvTrip || (flags_r.underVoltage && !clearCmd);
        end
    end

    assign faultFlags = flags_r;
    assign alertLineN = !(flags_r.overVoltage || flags_r.underVoltage);

    ////////////////////////////////////////////////////////////////////////////
    // Retry timer; counts from the trip that ends each attempt, not its start
    always_ff @(posedge sys_clk) begin
        if (rst || timerClr) begin
            tickCnt_r <= 32'h0;
            msCnt_r   <= 9'h000;
        end else begin
            tickCnt_r <= tick ? 32'h0 : tickCnt_r + 32'h1;
            if (tick && !timerDone)
                msCnt_r <= msCnt_r + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        timerClr  = 1'b0;
        unique case (state_r)
            ST_OFF: begin
                // No start while another fault still holds the unit down
                if (powerOk && !otherFaultShutdown) state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (ovTrip || uvTrip) begin
                    timerClr = 1'b1;
                    if (tripMode == MODE_WHILE)
                        state_nxt = ST_HOLD;
                    else if (tripRetry == RETRY_CONTINUOUS)
                        state_nxt = ST_WAIT;
                    else
                        state_nxt = ST_LATCH;
                end
            end
            ST_HOLD: begin
                if (!srcPresent) state_nxt = ST_RUN;
            end
            ST_LATCH: begin
                if (clearCmd) state_nxt = ST_RUN;
            end
            ST_WAIT: begin
                // No recheck of the fault itself, only time and OV margin
                if (timerDone && (!srcOv_r || ovBelowRestart)) begin
                    state_nxt = ST_RUN;
                    timerClr  = 1'b1;
                end
            end
        endcase
        if (otherFaultShutdown && state_r != ST_OFF)
            state_nxt = ST_LATCH;
        if (!powerOk)
            state_nxt = ST_OFF;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r   <= ST_OFF;
            actResp_r <= 8'h00;
            srcOv_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_RUN && (ovTrip || uvTrip)) begin
                actResp_r <= tripResp;
                srcOv_r   <= ovTrip;
            end
        end
    end

    // Output is cut in the same cycle the trip is seen
    assign outputEnable = (state_r == ST_RUN) && !ovTrip && !uvTrip;
endmodule : avfr_aux_voltage_fault_response

// ==== verilog/avfr_pkg.sv ====
// Purpose: Shared constants and types for the aux voltage fault response block
// Assumes: Command codes and defaults as used by the block's command port
// Notes:   Monitored voltage is unsigned Q16.16 volts
package avfr_pkg;
    // Command codes
    localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0]  CMD_OV_LIMIT     = 8'hf5;
    localparam logic [7:0]  CMD_UV_LIMIT     = 8'hf6;
    localparam logic [7:0]  CMD_OV_RESPONSE  = 8'hf8;
    localparam logic [7:0]  CMD_UV_RESPONSE  = 8'hf9;
    // Reset values
    localparam logic [7:0]  RESP_RESET       = 8'hbf;
    localparam logic [15:0] OV_LIMIT_RESET   = 16'hc266;
    localparam logic [15:0] UV_LIMIT_RESET   = 16'h9b33;
    // Response field layout
    localparam int          RESP_MODE_HI     = 7;
    localparam int          RESP_MODE_LO     = 6;
    localparam int          RESP_RETRY_HI    = 5;
    localparam int          RESP_RETRY_LO    = 3;
    localparam int          RESP_DELAY_HI    = 2;
    localparam int          RESP_DELAY_LO    = 0;
    localparam logic [1:0]  MODE_IGNORE      = 2'h0;
    localparam logic [1:0]  MODE_UNUSED      = 2'h1;
    localparam logic [1:0]  MODE_RETRY       = 2'h2;
    localparam logic [1:0]  MODE_WHILE       = 2'h3;
    localparam logic [2:0]  RETRY_NONE       = 3'h0;
    localparam logic [2:0]  RETRY_CONTINUOUS = 3'h7;
    // Linear-11 layout
    localparam int          LIN_EXP_LO       = 11;
    localparam int          LIN_MANT_HI      = 10;
    localparam int          FIX_FRAC_BITS    = 16;
    // Restart threshold, percent of the over-voltage limit
    localparam int          RESTART_PCT      = 95;
    localparam int          FULL_PCT         = 100;
    // Retry timing
    localparam int          RETRY_STEP_MS    = 35;
    localparam int          CLK_HZ           = 100_000_000;
    localparam int          MS_PER_S         = 1000;
    localparam int          CYCLES_PER_MS    = CLK_HZ / MS_PER_S;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } avfr_cmd_t;

    typedef struct packed {
        logic overVoltage;
        logic underVoltage;
    } avfr_flags_t;
endpackage : avfr_pkg
